// ==== rtl/mbt_client.sv ====
// Client end: sends one request and collects the response
`timescale 1ns/1ns
`default_nettype none
module mbt_client (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Link
  mbt_link_if.client       lk,
  // Request
  input  wire logic        i_start,
  input  wire logic [15:0] i_tid,
  input  wire logic [7:0]  i_unit,
  input  wire logic [7:0]  i_fc,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_count,
  // Result
  output logic             o_busy,
  output logic             o_done,
  output logic             o_tid_ok,
  output logic             o_exc,
  output logic [7:0]       o_exc_code,
  output logic [31:0]      o_value
);
  mbt_pkg::cli_state_t st_q;
  mbt_pkg::cli_state_t st_d;
  logic [3:0]  idx_q;
  logic [3:0]  idx_d;
  logic [7:0]  req_q [mbt_pkg::REQ_LEN];
  logic [7:0]  req_d [mbt_pkg::REQ_LEN];
  logic [7:0]  hdr_q [mbt_pkg::HDR_LEN];
  logic [7:0]  hdr_d [mbt_pkg::HDR_LEN];
  logic [7:0]  pdu_q [mbt_pkg::CPDU_MAX];
  logic [7:0]  pdu_d [mbt_pkg::CPDU_MAX];
  logic [15:0] rem_q;
  logic [15:0] rem_d;
  logic [15:0] pcnt_q;
  logic [15:0] pcnt_d;
  logic [15:0] tid_q;
  logic [15:0] tid_d;
  logic        vld_q;
  logic        vld_d;
  logic [7:0]  dat_q;
  logic [7:0]  dat_d;
  logic        rdy_q;
  logic        rdy_d;
  logic        done_q;
  logic        done_d;
  logic        tok_q;
  logic        tok_d;
  logic        exc_q;
  logic        exc_d;
  logic [7:0]  code_q;
  logic [7:0]  code_d;
  logic [31:0] value_q;
  logic [31:0] value_d;
  logic        take;
  logic [15:0] hdr_len;

  assign take    = rdy_q && lk.rsp_valid;
  assign hdr_len = {hdr_q[mbt_pkg::HDR_LEN_HI], hdr_q[mbt_pkg::HDR_LEN_LO]};

  // ==========================================================================
  // Request sequencing and response capture
  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    req_d   = req_q;
    hdr_d   = hdr_q;
    pdu_d   = pdu_q;
    rem_d   = rem_q;
    pcnt_d  = pcnt_q;
    tid_d   = tid_q;
    vld_d   = vld_q;
    dat_d   = dat_q;
    rdy_d   = rdy_q;
    done_d  = 1'b0;
    tok_d   = tok_q;
    exc_d   = exc_q;
    code_d  = code_q;
    value_d = value_q;
    case (st_q)
      mbt_pkg::CLI_IDLE: begin
        if (i_start) begin
          req_d[0]  = i_tid[15:8]; // see R2
          req_d[1]  = i_tid[7:0];
          req_d[2]  = mbt_pkg::PROTO_MODBUS[15:8]; // see R3
          req_d[3]  = mbt_pkg::PROTO_MODBUS[7:0];
          req_d[4]  = 8'h00;
          req_d[5]  = 8'(mbt_pkg::REQ_LEN - mbt_pkg::HDR_LEN + 1); // see R4
          req_d[6]  = i_unit;
          req_d[7]  = i_fc; // see R1
          req_d[8]  = i_addr[15:8]; // see R6
          req_d[9]  = i_addr[7:0];
          req_d[10] = i_count[15:8]; // see R8 see R10 see R18
          req_d[11] = i_count[7:0];
          tid_d     = i_tid;
          vld_d     = 1'b1;
          dat_d     = i_tid[15:8];
          idx_d     = 4'h0;
          st_d      = mbt_pkg::CLI_SEND;
        end
      end
      mbt_pkg::CLI_SEND: begin
        if (vld_q && lk.req_ready) begin
          if (idx_q == 4'(mbt_pkg::REQ_LEN - 1)) begin
            vld_d = 1'b0;
            rdy_d = 1'b1;
            idx_d = 4'h0;
            st_d  = mbt_pkg::CLI_HDR;
          end else begin
            idx_d = idx_q + 4'h1;
            dat_d = req_q[idx_q + 4'h1];
          end
        end
      end
      mbt_pkg::CLI_HDR: begin
        if (take) begin
          hdr_d[idx_q[2:0]] = lk.rsp_data;
          if (idx_q == 4'(mbt_pkg::HDR_LEN - 1)) begin
            idx_d  = 4'h0;
            pcnt_d = 16'h0000;
            if (hdr_len >= mbt_pkg::LEN_MIN) begin
              rem_d = hdr_len - 16'h0001;
              st_d  = mbt_pkg::CLI_PDU;
            end else begin
              rdy_d = 1'b0;
              st_d  = mbt_pkg::CLI_DONE;
            end
          end else begin
            idx_d = idx_q + 4'h1;
          end
        end
      end
      mbt_pkg::CLI_PDU: begin
        if (take) begin
          if (pcnt_q < 16'(mbt_pkg::CPDU_MAX)) begin
            pdu_d[pcnt_q[2:0]] = lk.rsp_data;
          end
          pcnt_d = pcnt_q + 16'h0001;
          rem_d  = rem_q - 16'h0001;
          if (rem_q == 16'h0001) begin
            rdy_d = 1'b0;
            st_d  = mbt_pkg::CLI_DONE;
          end
        end
      end
      mbt_pkg::CLI_DONE: begin
        done_d = 1'b1;
        tok_d  = ({hdr_q[0], hdr_q[1]} == tid_q);
        exc_d  = pdu_q[0][7];
        code_d = exc_d ? pdu_q[1] : 8'h00;
        if (pdu_q[1] == mbt_pkg::BC32) begin
          value_d = {pdu_q[2], pdu_q[3], pdu_q[4], pdu_q[5]};
        end else begin
          value_d = {16'h0000, pdu_q[2], pdu_q[3]};
        end
        st_d = mbt_pkg::CLI_IDLE;
      end
      default: begin
        st_d  = mbt_pkg::CLI_IDLE;
        vld_d = 1'b0;
        rdy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q    <= mbt_pkg::CLI_IDLE;
      idx_q   <= 4'h0;
      req_q   <= '{default: 8'h00};
      hdr_q   <= '{default: 8'h00};
      pdu_q   <= '{default: 8'h00};
      rem_q   <= 16'h0000;
      pcnt_q  <= 16'h0000;
      tid_q   <= 16'h0000;
      vld_q   <= 1'b0;
      dat_q   <= 8'h00;
      rdy_q   <= 1'b0;
      done_q  <= 1'b0;
      tok_q   <= 1'b0;
      exc_q   <= 1'b0;
      code_q  <= 8'h00;
      value_q <= 32'h0000_0000;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      req_q   <= req_d;
      hdr_q   <= hdr_d;
      pdu_q   <= pdu_d;
      rem_q   <= rem_d;
      pcnt_q  <= pcnt_d;
      tid_q   <= tid_d;
      vld_q   <= vld_d;
      dat_q   <= dat_d;
      rdy_q   <= rdy_d;
      done_q  <= done_d;
      tok_q   <= tok_d;
      exc_q   <= exc_d;
      code_q  <= code_d;
      value_q <= value_d;
    end
  end

  assign lk.req_valid = vld_q;
  assign lk.req_data  = dat_q;
  assign lk.rsp_ready = rdy_q;
  assign o_busy       = (st_q != mbt_pkg::CLI_IDLE);
  assign o_done       = done_q;
  assign o_tid_ok     = tok_q;
  assign o_exc        = exc_q;
  assign o_exc_code   = code_q;
  assign o_value      = value_q;
endmodule : mbt_client
`default_nettype wire

// ==== rtl/mbt_link_if.sv ====
// Byte stream link between client and server ends
`timescale 1ns/1ns
`default_nettype none
interface mbt_link_if;
  logic       req_valid;
  logic [7:0] req_data;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_ready;

  modport client (
    output req_valid,
    output req_data,
    input  req_ready,
    input  rsp_valid,
    input  rsp_data,
    output rsp_ready
  );

  modport server (
    input  req_valid,
    input  req_data,
    output req_ready,
    output rsp_valid,
    output rsp_data,
    input  rsp_ready
  );
endinterface : mbt_link_if
`default_nettype wire

// ==== rtl/mbt_pkg.sv ====
// Shared constants and types for the Modbus/TCP parameter link
`default_nettype none
package mbt_pkg;

  // ==========================================================================
  // Telegram layout
  localparam int          HDR_LEN      = 7;
  localparam int          HDR_LEN_HI   = 4;
  localparam int          HDR_LEN_LO   = 5;
  localparam int          HDR_UNIT     = 6;
  localparam int          PDU_MAX      = 16;
  localparam int          CPDU_MAX     = 6;
  localparam int          RESP_MAX     = 13;
  localparam int          REQ_LEN      = 12;
  localparam int          RSP_DATA     = 9;
  localparam logic [15:0] RD_PDU_LEN   = 16'h0005;
  localparam logic [15:0] LEN_MIN      = 16'h0002;
  localparam logic [15:0] PROTO_MODBUS = 16'h0000;
  localparam logic [15:0] TCP_PORT     = 16'h01F6;
  localparam logic [3:0]  RLEN_EXC     = 4'h9;
  localparam logic [3:0]  RLEN_16      = 4'hB;
  localparam logic [3:0]  RLEN_32      = 4'hD;

  // ==========================================================================
  // Function, count and exception codes
  localparam logic [7:0]  FC_RD        = 8'h03;
  localparam logic [7:0]  FC_WR1       = 8'h06;
  localparam logic [7:0]  FC_WRN       = 8'h10;
  localparam logic [7:0]  FC_RD32      = 8'h64;
  localparam logic [7:0]  FC_WR32      = 8'h65;
  localparam logic [7:0]  EXC_FLAG     = 8'h80;
  localparam logic [7:0]  EXC_FUNC     = 8'h01;
  localparam logic [7:0]  EXC_ADDR     = 8'h02;
  localparam logic [7:0]  EXC_VAL      = 8'h03;
  localparam logic [7:0]  EXC_DEV      = 8'h04;
  localparam logic [7:0]  BC16         = 8'h02;
  localparam logic [7:0]  BC32         = 8'h04;
  localparam logic [15:0] CNT16        = 16'h0001;
  localparam logic [15:0] CNT32        = 16'h0002;

  // ==========================================================================
  // Start address fields
  localparam int          PAR_W        = 12;
  localparam logic [11:0] PAR_MAX      = 12'h63F;
  localparam logic [3:0]  DSET_MAX     = 4'h9;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          MS_NS          = 1000000;
  localparam int          CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] TIMEOUT_MAX_MS = 16'hEA60;

  // ==========================================================================
  // States
  typedef enum logic [2:0] {
    SRV_HDR   = 3'b000,
    SRV_PDU   = 3'b001,
    SRV_CHECK = 3'b010,
    SRV_READ  = 3'b011,
    SRV_BUILD = 3'b100,
    SRV_SEND  = 3'b101
  } srv_state_t;

  typedef enum logic [2:0] {
    CLI_IDLE = 3'b000,
    CLI_SEND = 3'b001,
    CLI_HDR  = 3'b010,
    CLI_PDU  = 3'b011,
    CLI_DONE = 3'b100
  } cli_state_t;

  // ==========================================================================
  // Function code recognised by the server
  function automatic logic fc_known(input logic [7:0] fc);
    fc_known = (fc == FC_RD) || (fc == FC_WR1) || (fc == FC_WRN) ||
               (fc == FC_RD32) || (fc == FC_WR32);
  endfunction : fc_known

endpackage : mbt_pkg
`default_nettype wire

// ==== rtl/mbt_server.sv ====
// Server end: parses requests, reads parameters, builds responses
// Notes on behaviour
// R1: Header, then function code, then data
// R2: Transaction id echoed unchanged
// R3: Protocol id zero, echoed back
// R4: Length counts bytes after it
// R5: Unit id never evaluated
// R6: Multi-byte fields most significant first
// R7: Codes 3, 6, 16, 100, 101 recognised
// R8: 16-bit read: code 3, count 1
// R9: 16-bit reply: code 3, two bytes
// R10: 32-bit read: code 3, count 2
// R11: 32-bit reply: code 3, four bytes
// R12: Failed read: 0x83 plus exception code
// R13: Dataset top 4 bits, parameter low 12
// R14: Unknown parameter or bad count: code 2
// R15: Wrong data field size: code 3
// R16: Internal read failure: code 4
// R17: Fractional values scaled integers
// R18: Write request layout for code 6
// R19: Port 502, one request at a time
// R20: Timeout without good transfer raises fault
// R21: Reply only after whole request checked
// R22: Reply repeats request function code
`timescale 1ns/1ns
`default_nettype none
module mbt_server #(
  parameter int unsigned CYC_PER_MS = mbt_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Link
  mbt_link_if.server       lk,
  // Parameter store
  output logic             o_par_req,
  output logic [15:0]      o_par_addr,
  output logic             o_par_wide,
  input  wire logic        i_par_ack,
  input  wire logic        i_par_err,
  input  wire logic [31:0] i_par_data,
  // Supervision
  input  wire logic [15:0] i_timeout_ms,
  output logic             o_comm_timeout
);
  mbt_pkg::srv_state_t st_q;
  mbt_pkg::srv_state_t st_d;
  logic [3:0]  idx_q;
  logic [3:0]  idx_d;
  logic [7:0]  hdr_q  [mbt_pkg::HDR_LEN];
  logic [7:0]  hdr_d  [mbt_pkg::HDR_LEN];
  logic [7:0]  pdu_q  [mbt_pkg::PDU_MAX];
  logic [7:0]  pdu_d  [mbt_pkg::PDU_MAX];
  logic [7:0]  resp_q [mbt_pkg::RESP_MAX];
  logic [7:0]  resp_d [mbt_pkg::RESP_MAX];
  logic [15:0] rem_q;
  logic [15:0] rem_d;
  logic [15:0] pcnt_q;
  logic [15:0] pcnt_d;
  logic [3:0]  rlen_q;
  logic [3:0]  rlen_d;
  logic        ok_q;
  logic        ok_d;
  logic [7:0]  code_q;
  logic [7:0]  code_d;
  logic [31:0] val_q;
  logic [31:0] val_d;
  logic        wide_q;
  logic        wide_d;
  logic        req_rdy_q;
  logic        req_rdy_d;
  logic        rsp_vld_q;
  logic        rsp_vld_d;
  logic [7:0]  rsp_dat_q;
  logic [7:0]  rsp_dat_d;
  logic        par_req_q;
  logic        par_req_d;
  logic [15:0] par_addr_q;
  logic [15:0] par_addr_d;
  logic        good_q;
  logic        good_d;
  logic        take;
  logic [15:0] hdr_len;
  logic [15:0] st_addr;
  logic [15:0] reg_cnt;
  logic [31:0] val_al;

  assign take    = req_rdy_q && lk.req_valid;
  assign hdr_len = {hdr_q[mbt_pkg::HDR_LEN_HI], hdr_q[mbt_pkg::HDR_LEN_LO]};
  assign st_addr = {pdu_q[1], pdu_q[2]};
  assign reg_cnt = {pdu_q[3], pdu_q[4]};
  assign val_al  = wide_q ? val_q : {val_q[15:0], 16'h0000};

  // ==========================================================================
  // Request parsing and response building
  always_comb begin
    st_d       = st_q;
    idx_d      = idx_q;
    hdr_d      = hdr_q;
    pdu_d      = pdu_q;
    resp_d     = resp_q;
    rem_d      = rem_q;
    pcnt_d     = pcnt_q;
    rlen_d     = rlen_q;
    ok_d       = ok_q;
    code_d     = code_q;
    val_d      = val_q;
    wide_d     = wide_q;
    req_rdy_d  = req_rdy_q;
    rsp_vld_d  = rsp_vld_q;
    rsp_dat_d  = rsp_dat_q;
    par_req_d  = 1'b0;
    par_addr_d = par_addr_q;
    good_d     = 1'b0;
    case (st_q)
      mbt_pkg::SRV_HDR: begin
        if (take) begin
          hdr_d[idx_q[2:0]] = lk.req_data; // see R1
          if (idx_q == 4'(mbt_pkg::HDR_LEN - 1)) begin
            idx_d  = 4'h0;
            pcnt_d = 16'h0000;
            if (hdr_len >= mbt_pkg::LEN_MIN) begin
              rem_d = hdr_len - 16'h0001; // see R4
              st_d  = mbt_pkg::SRV_PDU;
            end
          end else begin
            idx_d = idx_q + 4'h1;
          end
        end
      end
      mbt_pkg::SRV_PDU: begin
        if (take) begin
          if (pcnt_q < 16'(mbt_pkg::PDU_MAX)) begin
            pdu_d[pcnt_q[3:0]] = lk.req_data;
          end
          pcnt_d = pcnt_q + 16'h0001;
          rem_d  = rem_q - 16'h0001;
          if (rem_q == 16'h0001) begin
            req_rdy_d = 1'b0; // see R19
            st_d      = mbt_pkg::SRV_CHECK; // see R21
          end
        end
      end
      mbt_pkg::SRV_CHECK: begin
        ok_d   = 1'b0;
        wide_d = (reg_cnt == mbt_pkg::CNT32);
        st_d   = mbt_pkg::SRV_BUILD;
        if (pdu_q[0] != mbt_pkg::FC_RD) begin
          code_d = mbt_pkg::fc_known(pdu_q[0]) ? mbt_pkg::EXC_DEV : mbt_pkg::EXC_FUNC; // see R7
        end else if (pcnt_q != mbt_pkg::RD_PDU_LEN) begin
          code_d = mbt_pkg::EXC_VAL; // see R15
        end else if ((reg_cnt != mbt_pkg::CNT16) && (reg_cnt != mbt_pkg::CNT32)) begin
          code_d = mbt_pkg::EXC_ADDR; // see R14
        end else if ((st_addr[mbt_pkg::PAR_W-1:0] > mbt_pkg::PAR_MAX) ||
                     (st_addr[15:mbt_pkg::PAR_W] > mbt_pkg::DSET_MAX)) begin
          code_d = mbt_pkg::EXC_ADDR; // see R13
        end else begin
          par_req_d  = 1'b1; // see R8
          par_addr_d = st_addr;
          st_d       = mbt_pkg::SRV_READ;
        end
      end
      mbt_pkg::SRV_READ: begin
        if (i_par_ack) begin
          ok_d   = !i_par_err;
          code_d = mbt_pkg::EXC_DEV; // see R16
          val_d  = i_par_data; // see R17
          st_d   = mbt_pkg::SRV_BUILD;
        end
      end
      mbt_pkg::SRV_BUILD: begin
        for (int b = 0; b < 4; b++) begin
          resp_d[b] = hdr_q[b]; // see R2
        end
        resp_d[mbt_pkg::HDR_LEN_HI] = 8'h00;
        resp_d[mbt_pkg::HDR_UNIT]   = hdr_q[mbt_pkg::HDR_UNIT]; // see R5
        for (int b = 0; b < 4; b++) begin
          resp_d[mbt_pkg::RSP_DATA + b] = val_al[8 * (3 - b) +: 8]; // see R6
        end
        if (ok_q) begin
          resp_d[7] = pdu_q[0]; // see R22
          resp_d[8] = wide_q ? mbt_pkg::BC32 : mbt_pkg::BC16; // see R9 see R11
          rlen_d    = wide_q ? mbt_pkg::RLEN_32 : mbt_pkg::RLEN_16; // see R10
        end else begin
          resp_d[7] = pdu_q[0] | mbt_pkg::EXC_FLAG; // see R12
          resp_d[8] = code_q;
          rlen_d    = mbt_pkg::RLEN_EXC;
        end
        resp_d[mbt_pkg::HDR_LEN_LO] = {4'h0, rlen_d - 4'(mbt_pkg::HDR_LEN - 1)}; // see R4
        rsp_vld_d = 1'b1;
        rsp_dat_d = hdr_q[0]; // see R2
        idx_d     = 4'h0;
        good_d    = ok_q;
        st_d      = mbt_pkg::SRV_SEND;
      end
      mbt_pkg::SRV_SEND: begin
        if (rsp_vld_q && lk.rsp_ready) begin
          if (idx_q == rlen_q - 4'h1) begin
            rsp_vld_d = 1'b0;
            req_rdy_d = 1'b1;
            idx_d     = 4'h0;
            st_d      = mbt_pkg::SRV_HDR;
          end else begin
            idx_d     = idx_q + 4'h1;
            rsp_dat_d = resp_q[idx_q + 4'h1];
          end
        end
      end
      default: begin
        st_d      = mbt_pkg::SRV_HDR;
        idx_d     = 4'h0;
        req_rdy_d = 1'b1;
        rsp_vld_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q       <= mbt_pkg::SRV_HDR;
      idx_q      <= 4'h0;
      hdr_q      <= '{default: 8'h00};
      pdu_q      <= '{default: 8'h00};
      resp_q     <= '{default: 8'h00};
      rem_q      <= 16'h0000;
      pcnt_q     <= 16'h0000;
      rlen_q     <= 4'h0;
      ok_q       <= 1'b0;
      code_q     <= 8'h00;
      val_q      <= 32'h0000_0000;
      wide_q     <= 1'b0;
      req_rdy_q  <= 1'b1;
      rsp_vld_q  <= 1'b0;
      rsp_dat_q  <= 8'h00;
      par_req_q  <= 1'b0;
      par_addr_q <= 16'h0000;
      good_q     <= 1'b0;
    end else begin
      st_q       <= st_d;
      idx_q      <= idx_d;
      hdr_q      <= hdr_d;
      pdu_q      <= pdu_d;
      resp_q     <= resp_d;
      rem_q      <= rem_d;
      pcnt_q     <= pcnt_d;
      rlen_q     <= rlen_d;
      ok_q       <= ok_d;
      code_q     <= code_d;
      val_q      <= val_d;
      wide_q     <= wide_d;
      req_rdy_q  <= req_rdy_d;
      rsp_vld_q  <= rsp_vld_d;
      rsp_dat_q  <= rsp_dat_d;
      par_req_q  <= par_req_d;
      par_addr_q <= par_addr_d;
      good_q     <= good_d;
    end
  end

  // ==========================================================================
  // Timeout supervision
  mbt_timeout_mon #(
    .CYC_PER_MS (CYC_PER_MS)
  ) mbt_timeout_mon_inst (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_good     (good_q), // see R20
    .i_limit_ms (i_timeout_ms),
    .o_fault    (o_comm_timeout)
  );

  assign lk.req_ready = req_rdy_q;
  assign lk.rsp_valid = rsp_vld_q;
  assign lk.rsp_data  = rsp_dat_q;
  assign o_par_req    = par_req_q;
  assign o_par_addr   = par_addr_q;
  assign o_par_wide   = wide_q;
endmodule : mbt_server
`default_nettype wire

// ==== rtl/mbt_timeout_mon.sv ====
// Communication timeout monitor
`timescale 1ns/1ns
`default_nettype none
module mbt_timeout_mon #(
  parameter int unsigned CYC_PER_MS = mbt_pkg::CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Control
  input  wire logic        i_good,
  input  wire logic [15:0] i_limit_ms,
  // Status
  output logic             o_fault
);
  localparam int CW = $clog2(CYC_PER_MS + 1);

  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  logic [15:0]   ms_q;
  logic [15:0]   ms_d;
  logic          fault_q;
  logic          fault_d;

  // ==========================================================================
  // Millisecond counting since last good transfer
  always_comb begin
    cyc_d   = cyc_q;
    ms_d    = ms_q;
    fault_d = fault_q;
    if (i_limit_ms == 16'h0000) begin
      cyc_d   = '0;
      ms_d    = 16'h0000;
      fault_d = 1'b0;
    end else if (i_good) begin
      cyc_d   = '0;
      ms_d    = 16'h0000;
      fault_d = 1'b0;
    end else if (!fault_q) begin
      if (cyc_q == CW'(CYC_PER_MS - 1)) begin
        cyc_d = '0;
        ms_d  = ms_q + 16'h0001;
        if (ms_q + 16'h0001 >= i_limit_ms) begin
          fault_d = 1'b1; // see R20
        end
      end else begin
        cyc_d = cyc_q + CW'(1);
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cyc_q   <= '0;
      ms_q    <= 16'h0000;
      fault_q <= 1'b0;
    end else begin
      cyc_q   <= cyc_d;
      ms_q    <= ms_d;
      fault_q <= fault_d;
    end
  end

  assign o_fault = fault_q;
endmodule : mbt_timeout_mon
`default_nettype wire

// ==== sim/mbt_link_asserts.sv ====
// Protocol checker for the request and response byte streams
`timescale 1ns/1ns
`default_nettype none
module mbt_link_asserts (
  // Clock, reset and link
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       req_valid,
  input wire logic [7:0] req_data,
  input wire logic       req_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic       rsp_ready
);
  // ==========================================================================
  // Byte tracking
  logic [7:0] qn_q;
  logic [7:0] sn_q;
  logic [7:0] len_q;
  logic [7:0] fc_q;
  logic [7:0] rq_q [16];
  wire  [7:0] qi = (sn_q != 8'h00) ? 8'h00 : qn_q;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      qn_q <= 8'h00;
      sn_q <= 8'h00;
    end else if (req_valid && req_ready) begin
      qn_q <= qi + 8'h01;
      sn_q <= 8'h00;
      rq_q[qi[3:0]] <= req_data;
    end else if (rsp_valid && rsp_ready) begin
      sn_q <= sn_q + 8'h01;
      if (sn_q == 8'h05) len_q <= rsp_data;
      if (sn_q == 8'h07) fc_q <= rsp_data;
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_req_hold; req_valid && !req_ready |=> req_valid && $stable(req_data); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request byte dropped");
  property p_rsp_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("response byte dropped");
  property p_one_open; rsp_valid |-> !req_ready; endproperty
  a_one_open: assert property (p_one_open) else $error("request taken in reply");
  property p_whole; rsp_valid && sn_q == 8'h00 |-> qn_q == rq_q[5] + 8'h06; endproperty
  a_whole: assert property (p_whole) else $error("reply before full request");
  property p_tid; rsp_valid && sn_q < 8'h02 |-> rsp_data == rq_q[sn_q[3:0]]; endproperty
  a_tid: assert property (p_tid) else $error("transaction id not echoed");
  property p_proto; rsp_valid && sn_q inside {8'h02, 8'h03} |-> rsp_data == 8'h00; endproperty
  a_proto: assert property (p_proto) else $error("protocol id not zero");
  property p_unit; rsp_valid && sn_q == 8'h06 |-> rsp_data == rq_q[6]; endproperty
  a_unit: assert property (p_unit) else $error("unit id not echoed");
  property p_len; $rose(req_ready) |-> sn_q == len_q + 8'h06; endproperty
  a_len: assert property (p_len) else $error("length field wrong");
  property p_fc; rsp_valid && sn_q == 8'h07 |-> rsp_data[6:0] == rq_q[7][6:0]; endproperty
  a_fc: assert property (p_fc) else $error("function code not repeated");
  property p_bc; rsp_valid && sn_q == 8'h08 && !fc_q[7] |-> rsp_data == {rq_q[11][6:0], 1'b0};
  endproperty
  a_bc: assert property (p_bc) else $error("byte count wrong");
  property p_exc; rsp_valid && sn_q == 8'h08 && fc_q[7] |-> rsp_data inside {[1:4]}; endproperty
  a_exc: assert property (p_exc) else $error("exception code out of range");

  c_exc: cover property (rsp_valid && sn_q == 8'h08 && fc_q[7]);
  c_wide: cover property (rsp_valid && sn_q == 8'h0C);
  c_end: cover property ($rose(req_ready));
endmodule : mbt_link_asserts
`default_nettype wire

// ==== sim/modbus_tcp_param_server_test.sv ====
// Testbench: client and server joined back to back
`timescale 1ns/1ns
`default_nettype none
module modbus_tcp_param_server_test;
  logic        clk, rst_n, start, ack, err, perr, busy, done, tid_ok, exc, preq, wide, fault;
  logic [7:0]  fc, exc_code;
  logic [15:0] tid, addr, cnt, tmo, paddr;
  logic [31:0] pdata, pval, value;
  int          n_mismatch, samples_checked;

  mbt_link_if lk ();
  mbt_server #(.CYC_PER_MS(4)) mbt_server_inst (.i_core_clk(clk), .i_rst_n(rst_n), .lk(lk),
    .o_par_req(preq), .o_par_addr(paddr), .o_par_wide(wide), .i_par_ack(ack), .i_par_err(err),
    .i_par_data(pdata), .i_timeout_ms(tmo), .o_comm_timeout(fault));
  mbt_client mbt_client_inst (.i_core_clk(clk), .i_rst_n(rst_n), .lk(lk), .i_start(start),
    .i_tid(tid), .i_unit(tid[7:0]), .i_fc(fc), .i_addr(addr), .i_count(cnt), .o_busy(busy),
    .o_done(done), .o_tid_ok(tid_ok), .o_exc(exc), .o_exc_code(exc_code), .o_value(value));
  mbt_link_asserts mbt_link_asserts_inst (.i_core_clk(clk), .i_rst_n(rst_n),
    .req_valid(lk.req_valid), .req_data(lk.req_data), .req_ready(lk.req_ready),
    .rsp_valid(lk.rsp_valid), .rsp_data(lk.rsp_data), .rsp_ready(lk.rsp_ready));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Parameter store answers one cycle after each request
  always @(negedge clk) begin
    ack <= 1'b0;
    if (preq === 1'b1) begin
      ack <= 1'b1;
      err <= perr;
      pdata <= pval;
      chk("par_addr", 32'(addr), 32'(paddr));
      chk("par_wide", 32'(cnt == 16'h0002), 32'(wide));
    end
  end

  task run(input logic [7:0] f, input logic [15:0] a, c, input logic [7:0] ec,
           input logic [31:0] ev);
    int i;
    @(negedge clk);
    fc = f;
    addr = a;
    cnt = c;
    tid = tid + 16'h1357;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk("busy", 32'h1, 32'(busy));
    for (i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    chk("done", 32'h1, 32'(done));
    chk("busy", 32'h0, 32'(busy));
    chk("exc", 32'(ec != 8'h00), 32'(exc));
    chk("tid_ok", 32'h1, 32'(tid_ok));
    chk("exc_code", 32'(ec), 32'(exc_code));
    if (ec == 8'h00) chk("value", ev, value);
  endtask : run

  task t_read16;
    pval = 32'hA5A5_0067;
    run(8'h03, 16'h2174, 16'h0001, 8'h00, 32'h0000_0067);
  endtask : t_read16

  task t_read32;
    pval = 32'h1234_5678;
    run(8'h03, 16'h963F, 16'h0002, 8'h00, 32'h1234_5678);
  endtask : t_read32

  task t_bad;
    run(8'h03, 16'h0640, 16'h0001, 8'h02, 32'h0);
    run(8'h03, 16'hA000, 16'h0001, 8'h02, 32'h0);
    run(8'h03, 16'h0001, 16'h0003, 8'h02, 32'h0);
  endtask : t_bad

  task t_fail;
    perr = 1'b1;
    run(8'h03, 16'h0005, 16'h0001, 8'h04, 32'h0);
    perr = 1'b0;
  endtask : t_fail

  task t_codes;
    logic [7:0] k [5];
    k = '{8'h06, 8'h10, 8'h64, 8'h65, 8'h2B};
    foreach (k[j]) run(k[j], 16'h0001, 16'h0001, (j < 4) ? 8'h04 : 8'h01, 32'h0);
  endtask : t_codes

  task t_timeout;
    tmo = 16'h0010;
    repeat (63) @(negedge clk);
    chk("fault", 32'h0, 32'(fault));
    repeat (17) @(negedge clk);
    chk("fault", 32'h1, 32'(fault));
    t_read16;
    chk("fault", 32'h0, 32'(fault));
    tmo = 16'h0000;
    repeat (80) @(negedge clk);
    chk("fault", 32'h0, 32'(fault));
  endtask : t_timeout

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    {rst_n, start, perr, fc, addr, cnt, tid, tmo, pval} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_read16;
    t_read32;
    t_bad;
    t_fail;
    t_codes;
    t_timeout;
    summarize;
  end

  initial begin
    #20000;
    n_mismatch++;
    summarize;
  end
endmodule : modbus_tcp_param_server_test
`default_nettype wire
